/* File: shared/tbw_pkg.sv */
/*
 tbw_pkg: shared constants for the block tape write/check controller.
 assumes: 12-bit tape words, registers on a 32-bit apb word map.
*/
package tbw_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_TAC = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0C;
	localparam logic [7:0] OFF_BLOCK = 8'h10;
	localparam logic [7:0] OFF_ADDR = 8'h14;
	localparam logic [7:0] OFF_MARKWIN = 8'h18;
	// ctrl field positions
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_NOPAUSE = 3;
	localparam int CTRL_KEEPMOVE = 4;
	localparam int CTRL_FMT = 5;
	localparam int CTRL_GO = 8;
	localparam int CTRL_PRESET = 9;
	// block register field positions
	localparam int BLK_GROUP_LSB = 12;
	localparam logic [11:0] GOOD_SUM = 12'hFFF;
	localparam logic [11:0] WORD_RST = 12'h000;
	localparam logic [1:0] LC_SET = 2'h3;
	localparam logic [1:0] LC_REQ = 2'h2;
	localparam logic [1:0] LC_LOAD = 2'h0;
	localparam logic [1:0] TCNT_LAST = 2'h3;
	typedef enum logic [2:0] {
		OP_PLAIN_WRITE = 3'h4,
		OP_WRITE_CHECK = 3'h5,
		OP_GROUP_WRITE_CHECK = 3'h6,
		OP_CHECK_ONLY = 3'h7,
		OP_MOVE_TO_BLOCK = 3'h3
	} tbw_op_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SEARCH = 5'h02,
		ST_BLOCK = 5'h04,
		ST_CHECK_WORD = 5'h08,
		ST_TURN = 5'h10
	} tbw_state_t;
	// synchronised pin vector layout
	localparam int PIN_TP = 0;
	localparam int PIN_TS1 = 5;
	localparam int PIN_TS4 = 6;
	localparam int PIN_BM = 7;
	localparam int PIN_DM = 8;
	localparam int PIN_FM = 9;
	localparam int PIN_CM = 10;
	localparam int PIN_FWD = 11;
	localparam int PIN_CLOSE = 12;
	localparam int PIN_RD = 13;
	localparam int PIN_FCLK = 16;
	localparam int PIN_ONLINE = 17;
	localparam int PIN_REMOTE = 18;
	localparam int PIN_WREN = 19;
	localparam int PIN_W = 20;
endpackage

/* File: rtl/tbw_sync.sv */
/*
 tbw_sync: two-flop synchroniser bank for tape-side pins.
 assumes: inputs are asynchronous levels; one clock, synchronous reset.
*/
`timescale 1ns/1ns
module tbw_sync #(
	parameter int W = 20
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // sync reset, active low
	input wire logic [W-1:0] d, // raw pins
	output logic [W-1:0] q // synchronised pins
);
	logic [W-1:0] meta;
	if (W < 1) begin : g_w_check
		$error("tbw_sync: W must be positive");
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

/* File: rtl/tbw_ctrl.sv */
/*
 tbw_ctrl: tape block write / check controller with apb register access.
 assumes: tape phase pulses, marks and read data arrive as async pins;
 the processor services transfer_request by writing the data register.
*/
// Contract
// R01 - block mark sets line counter; request two counts later
// R02 - processor delivers fetched word into tape buffer
// R03 - phase 0 adds buffer to sum, loads shifter
// R04 - phase 3 toggles writes, four lines per word
// R05 - final mark records complemented datasum
// R06 - final mark phase 2 enters check word
// R07 - write sync/write set then clear at check
// R08 - plain write ends; write-check goes to check
// R09 - group write repeats until group equal
// R10 - checking loads buffer and sums, no transfer
// R11 - check mark sums, hands sum to processor
// R12 - check-only ends after check mark
// R13 - bad check rewrites block until good
// R14 - group bad check rewrites remaining group blocks
// R15 - format clock halved into timing wave
// R16 - mark window shifted out on mark track
// R17 - idle entry conditions
// R18 - search set phase 1, cleared on find
// R19 - block only from search, qualifies requests
// R20 - turn around set/clear, stops motion
// R21 - write cycle set/clear and gating
// R22 - tape ready from switch settings
// R23 - processor increments address, clears request
// R24 - no-pause: request only when word ready
// R25 - preset clears states and write flops
`timescale 1ns/1ns
module tbw_ctrl
	import tbw_pkg::*;
(
	input wire logic clk, // 50 MHz clock
	input wire logic rst_b, // sync reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [4:0] phase_pulse, // tape phase pulses 0..4
	input wire logic timing_state_1, // tape timing state 1
	input wire logic timing_state_4, // tape timing state 4
	input wire logic block_mark, // decoded block mark
	input wire logic data_mark, // decoded data mark
	input wire logic final_mark, // decoded final mark
	input wire logic check_mark, // decoded check mark
	input wire logic forward, // transport moving forward
	input wire logic timing_window_closure, // timing fault
	input wire logic [2:0] read_data, // data track read bits
	input wire logic format_clock, // 7.5 us formatting clock
	input wire logic unit_online, // unit selector on line
	input wire logic unit_remote, // switch at remote
	input wire logic unit_write_enabled, // write lock enabled
	output logic [2:0] write_line, // data track write outputs
	output logic write_amp_enable, // write flop, amps on
	output logic polarity, // check word phase level
	output logic transfer_request, // break request
	output logic [11:0] tape_bus, // sum to processor accumulator
	output logic checksum_load, // one-cycle accumulator load
	output logic motion_stop, // stop transport
	output logic tape_ready, // transport ready
	output logic timing_track_wave, // timing track square wave
	output logic mark_track_out // mark track serial data
);
	logic [PIN_W-1:0] s2, s3, pe;
	tbw_state_t state;
	tbw_op_t op;
	logic no_pause, keep_moving, format_en, progress, write_cycle, write_sync;
	logic done_flag, chk_bad;
	logic [11:0] tape_buffer, tape_accumulator, read_write_shift_register, tape_memory_address, target;
	logic [2:0] group, group_count, chk_base;
	logic [1:0] lc, tcnt;
	logic [3:0] mark_window;
	logic wr_setup, wr_ctrl, wr_data, wr_block, wr_addr, wr_mwin, rd_status, setup, preset;
	logic p0, p1, p2, p3, p4, ts1e, ts4, bm, dm, fm, cm, fwd, fmt_tick, wpass;
	logic group_equal_flag, decide, sum_good, next_done, in_write, hit, mtb_end;
	logic [11:0] cur_block;

	function automatic logic [11:0] ones_add(input logic [11:0] a, input logic [11:0] b);
		logic [12:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[11:0] + {11'h000, s[12]};
	endfunction

	tbw_sync #(.W(PIN_W)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d({unit_write_enabled, unit_remote, unit_online, format_clock, read_data, timing_window_closure,
			forward, check_mark, final_mark, data_mark, block_mark, timing_state_4, timing_state_1,
			phase_pulse}),
		.q(s2)
	);

	// edge detect compares the second stage with a third
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s3 <= '0;
		end else begin
			s3 <= s2;
		end
	end
	assign pe = s2 & ~s3;
	assign p0 = pe[PIN_TP];
	assign p1 = pe[PIN_TP+1];
	assign p2 = pe[PIN_TP+2];
	assign p3 = pe[PIN_TP+3];
	assign p4 = pe[PIN_TP+4];
	assign ts1e = pe[PIN_TS1];
	assign ts4 = s2[PIN_TS4];
	assign bm = s2[PIN_BM];
	assign dm = s2[PIN_DM];
	assign fm = s2[PIN_FM];
	assign cm = s2[PIN_CM];
	assign fwd = s2[PIN_FWD];
	assign fmt_tick = pe[PIN_FCLK];

	// apb decode: writes act in the access phase, zero wait states
	assign wr_setup = psel & penable & pwrite;
	assign wr_ctrl = wr_setup & (paddr == OFF_CTRL);
	assign wr_data = wr_setup & (paddr == OFF_DATA);
	assign wr_block = wr_setup & (paddr == OFF_BLOCK);
	assign wr_addr = wr_setup & (paddr == OFF_ADDR);
	assign wr_mwin = wr_setup & (paddr == OFF_MARKWIN);
	assign rd_status = psel & penable & ~pwrite & (paddr == OFF_STATUS);
	assign setup = wr_ctrl & pwdata[CTRL_GO];
	assign preset = wr_ctrl & pwdata[CTRL_PRESET];

	assign wpass = write_cycle & (op == OP_PLAIN_WRITE || op == OP_WRITE_CHECK || op == OP_GROUP_WRITE_CHECK);
	assign in_write = wpass & (state == ST_BLOCK || state == ST_CHECK_WORD);
	assign group_equal_flag = (group_count == group);
	assign cur_block = target + {9'h000, group_count};
	assign hit = (state == ST_SEARCH) & p2 & (tape_accumulator == GOOD_SUM) & fwd & (op != OP_MOVE_TO_BLOCK);
	assign mtb_end = (state == ST_SEARCH) & p2 & bm & (op == OP_MOVE_TO_BLOCK);
	assign decide = (state == ST_CHECK_WORD) & cm & p1;
	assign sum_good = (tape_accumulator == GOOD_SUM);

	// end-of-block decision: finish the instruction or go round again
	always_comb begin
		next_done = 1'b0;
		chk_bad = 1'b0;
		if (wpass) begin
			next_done = (op == OP_PLAIN_WRITE); // [R08]
		end else begin
			chk_bad = !sum_good && op != OP_CHECK_ONLY; // [R13] [R14]
			next_done = (op == OP_CHECK_ONLY) || (sum_good && (op != OP_GROUP_WRITE_CHECK || group_equal_flag)); // [R12]
		end
	end

	// major state machine
	always_ff @(posedge clk) begin
		if (!rst_b || preset || setup || s2[PIN_CLOSE]) begin
			state <= ST_IDLE; // [R17] [R25]
		end else begin
			case (state)
				ST_IDLE: begin
					if (progress && p1) state <= ST_SEARCH; // [R18]
				end
				ST_SEARCH: begin
					if (hit) state <= ST_BLOCK; // [R18] [R19]
					else if (mtb_end) state <= ST_IDLE; // [R18]
				end
				ST_BLOCK: begin
					if (p2 && (wpass ? fm : cm)) state <= ST_CHECK_WORD; // [R06] [R11]
				end
				ST_CHECK_WORD: begin
					if (decide) state <= next_done ? ST_TURN : ST_IDLE; // [R20] [R17]
				end
				ST_TURN: begin
					if ((p1 && bm) || p2) state <= ST_IDLE; // [R20] [R17]
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// instruction control and progress
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			op <= OP_CHECK_ONLY;
			no_pause <= 1'b0;
			keep_moving <= 1'b0;
			format_en <= 1'b0;
			progress <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				op <= tbw_op_t'(pwdata[CTRL_OP_LSB +: 3]);
				no_pause <= pwdata[CTRL_NOPAUSE];
				keep_moving <= pwdata[CTRL_KEEPMOVE];
				format_en <= pwdata[CTRL_FMT];
			end
			if (preset) progress <= 1'b0;
			else if (setup) progress <= 1'b1;
			else if ((decide && next_done) || mtb_end) progress <= 1'b0; // [R08] [R12]
		end
	end

	// done is sticky; a finish in the same cycle as the status read wins
	always_ff @(posedge clk) begin
		if (!rst_b) done_flag <= 1'b0;
		else if ((decide && next_done) || mtb_end) done_flag <= 1'b1;
		else if (rd_status) done_flag <= 1'b0;
	end

	// write cycle and group counting
	always_ff @(posedge clk) begin
		if (!rst_b || preset) begin
			write_cycle <= 1'b0;
			group_count <= 3'h0;
			chk_base <= 3'h0;
		end else if (setup) begin
			write_cycle <= 1'b1; // [R21]
			group_count <= 3'h0;
			chk_base <= 3'h0;
		end else if (decide && next_done) begin
			write_cycle <= 1'b0; // [R08] [R21]
		end else if (decide) begin
			if (wpass) begin
				if (op == OP_GROUP_WRITE_CHECK && !group_equal_flag) begin
					group_count <= group_count + 3'h1; // [R09] [R21]
				end else begin
					write_cycle <= 1'b0; // [R08] [R21]
					group_count <= chk_base; // [R09]
				end
			end else if (chk_bad) begin
				write_cycle <= 1'b1; // [R13] [R21]
				chk_base <= group_count; // [R14]
			end else begin
				group_count <= group_count + 3'h1; // [R14]
			end
		end
	end

	// write sync / write flops; wpass (write cycle and a write op) holds writing off while checking
	always_ff @(posedge clk) begin
		if (!rst_b || preset || setup || (cm && ts1e)) begin
			write_sync <= 1'b0; // [R07] [R25]
			write_amp_enable <= 1'b0;
		end else begin
			if (state == ST_BLOCK && wpass && p1) write_sync <= 1'b1; // [R07]
			if (write_sync && write_cycle && p3) write_amp_enable <= 1'b1; // [R07] [R21]
		end
	end

	// line counter and transfer request
	always_ff @(posedge clk) begin
		if (!rst_b || preset || setup) begin
			lc <= 2'h0; // [R25]
			transfer_request <= 1'b0;
		end else begin
			if ((state == ST_SEARCH || state == ST_BLOCK) && wpass && bm && p4) lc <= LC_SET; // [R01]
			else if (state == ST_BLOCK && wpass && p3) lc <= lc - 2'h1;
			// a word is asked for only when the shifter will need it
			if (wr_data) transfer_request <= 1'b0; // [R23]
			else if (state == ST_BLOCK && wpass && p3 && lc == LC_REQ && !fm) transfer_request <= 1'b1; // [R01] [R19] [R24]
		end
	end

	// tape buffer
	always_ff @(posedge clk) begin
		if (!rst_b) tape_buffer <= WORD_RST;
		else if (wr_data) tape_buffer <= pwdata[11:0]; // [R02]
		else if (in_write && fm && p4) tape_buffer <= tape_accumulator; // [R05]
		else if (state == ST_BLOCK && !wpass && (dm || fm || cm) && ts4 && p4) tape_buffer <= read_write_shift_register; // [R10]
	end

	// tape accumulator: search compare, then datasum
	always_ff @(posedge clk) begin
		if (!rst_b || preset || setup) tape_accumulator <= WORD_RST;
		else if (state == ST_IDLE && progress && p1) tape_accumulator <= cur_block;
		else if (state == ST_SEARCH && bm && p1) tape_accumulator <= ones_add(tape_accumulator, read_write_shift_register);
		else if (hit) tape_accumulator <= WORD_RST;
		else if (state == ST_BLOCK && p0 && wpass && lc == LC_LOAD && !fm) begin
			tape_accumulator <= ones_add(tape_accumulator, tape_buffer); // [R03]
		end else if (state == ST_BLOCK && p0 && !wpass && (dm || fm || cm)) begin
			tape_accumulator <= ones_add(tape_accumulator, tape_buffer); // [R10] [R11]
		end
	end

	// read/write shifter: three four-bit lanes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			read_write_shift_register <= WORD_RST;
		end else if (in_write && p0 && lc == LC_LOAD) begin
			read_write_shift_register <= tape_buffer; // [R03] [R05]
		end else if (in_write && p3) begin
			read_write_shift_register <= {read_write_shift_register[10:8], 1'b0, read_write_shift_register[6:4], 1'b0,
				read_write_shift_register[2:0], 1'b0}; // [R04]
		end else if (!in_write && p3) begin
			read_write_shift_register <= {read_write_shift_register[10:8], s2[PIN_RD+2], read_write_shift_register[6:4],
				s2[PIN_RD+1], read_write_shift_register[2:0], s2[PIN_RD]};
		end
	end

	// line writer: check word flips polarity so the sum goes down complemented
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			write_line <= 3'h0;
			polarity <= 1'b0;
		end else begin
			polarity <= (state == ST_CHECK_WORD); // [R06]
			if (in_write && write_amp_enable && p3) begin
				write_line <= write_line ^ ({read_write_shift_register[11], read_write_shift_register[7],
					read_write_shift_register[3]} ^ {3{state == ST_CHECK_WORD}}); // [R04] [R05]
			end
		end
	end

	// checksum hand-over to the processor; suppressed when it keeps running
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tape_bus <= WORD_RST;
			checksum_load <= 1'b0;
		end else begin
			checksum_load <= 1'b0;
			if (state == ST_BLOCK && !wpass && cm && ts1e && !no_pause) begin
				tape_bus <= tape_accumulator; // [R11]
				checksum_load <= 1'b1;
			end
		end
	end

	// motion stop after turn around
	always_ff @(posedge clk) begin
		if (!rst_b || setup) motion_stop <= 1'b0;
		else if (state == ST_TURN && p1 && bm && !keep_moving) motion_stop <= 1'b1; // [R20]
	end

	always_ff @(posedge clk) begin
		if (!rst_b) tape_ready <= 1'b0;
		else tape_ready <= s2[PIN_ONLINE] & s2[PIN_REMOTE] & (s2[PIN_WREN] | ~op[2]); // [R22]
	end

	// formatting: two-bit time counter on the formatting clock
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tcnt <= 2'h0;
			timing_track_wave <= 1'b0;
			mark_window <= 4'h0;
			mark_track_out <= 1'b0;
		end else begin
			if (wr_mwin) mark_window <= pwdata[3:0]; // [R16]
			if (format_en && fmt_tick) begin
				tcnt <= tcnt + 2'h1; // [R15]
				timing_track_wave <= ~tcnt[0]; // [R15]
				if (tcnt == TCNT_LAST && !wr_mwin) begin
					mark_track_out <= mark_window[3]; // [R16]
					mark_window <= {mark_window[2:0], 1'b0};
				end
			end
		end
	end

	// target block, group size and memory address
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			target <= WORD_RST;
			group <= 3'h0;
			tape_memory_address <= WORD_RST;
		end else begin
			if (wr_block) begin
				target <= pwdata[11:0];
				group <= pwdata[BLK_GROUP_LSB +: 3];
			end
			if (wr_addr) tape_memory_address <= pwdata[11:0];
			else if (wr_data) tape_memory_address <= tape_memory_address + 12'h001; // [R23]
		end
	end

	// apb read data is registered in the setup phase
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				pslverr <= 1'b0;
				case (paddr)
					OFF_CTRL: prdata <= {26'h0, format_en, keep_moving, no_pause, op};
					OFF_STATUS: prdata <= {16'h0, done_flag, progress, write_cycle, write_sync, group_equal_flag,
						group_count, 3'h0, state};
					OFF_TAC: prdata <= {20'h0, tape_accumulator};
					OFF_DATA: prdata <= {20'h0, tape_bus};
					OFF_BLOCK: prdata <= {17'h0, group, target};
					OFF_ADDR: prdata <= {20'h0, tape_memory_address};
					OFF_MARKWIN: prdata <= {28'h0, mark_window};
					default: begin
						prdata <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule

/* File: verif/tbw_ctrl_chk.sv */
/*
 tbw_ctrl_chk: port-level assertions for tbw_ctrl.
 assumes: bound to tbw_ctrl, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
module tbw_ctrl_chk
	import tbw_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst_b, // reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic [4:0] phase_pulse, // phase pins
	input wire logic timing_state_1, // ts1 pin
	input wire logic check_mark, // mark pin
	input wire logic format_clock, // format pin
	input wire logic unit_online, // switch
	input wire logic unit_remote, // switch
	input wire logic [2:0] write_line, // data writes
	input wire logic write_amp_enable, // amps
	input wire logic transfer_request, // request
	input wire logic checksum_load, // sum load
	input wire logic motion_stop, // stop
	input wire logic tape_ready, // ready
	input wire logic timing_track_wave // timing wave
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic fc_q;
	logic p3_q;
	logic [3:0] fc_age;
	logic [3:0] p3_age;
	// cycles since a raw pin edge; the synchroniser delays outputs by three
	always_ff @(posedge clk) begin
		fc_q <= format_clock;
		p3_q <= phase_pulse[3];
		if (!rst_b || (format_clock && !fc_q))
			fc_age <= 4'h0;
		else if (fc_age != 4'hF)
			fc_age <= fc_age + 4'h1;
		if (!rst_b || (phase_pulse[3] && !p3_q))
			p3_age <= 4'h0;
		else if (p3_age != 4'hF)
			p3_age <= p3_age + 4'h1;
	end
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_go;
		psel && penable && pwrite && paddr == OFF_CTRL && pwdata[CTRL_GO];
	endsequence
	sequence s_cm_ts1;
		check_mark && $rose(timing_state_1);
	endsequence
	a_apb_ready: assert property (s_access |-> pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (psel && penable && paddr > OFF_MARKWIN |-> pslverr)
		else $error("unmapped access without error");
	a_data_clears: assert property (psel && penable && pwrite && paddr == OFF_DATA |=> !transfer_request)
		else $error("request kept after data write");
	a_load_pulse: assert property (checksum_load |=> !checksum_load)
		else $error("sum load longer than one cycle");
	a_amp_off: assert property (s_cm_ts1 |-> ##[1:8] !write_amp_enable)
		else $error("write amps stay on after check mark");
	a_ready_off: assert property (!(unit_online && unit_remote) [*6] |-> !tape_ready)
		else $error("ready with transport not usable");
	a_wave_hold: assert property (fc_age > 4'h8 |-> $stable(timing_track_wave))
		else $error("timing wave moved without format clock");
	a_line_hold: assert property (p3_age > 4'h8 |-> $stable(write_line))
		else $error("write lines moved away from phase 3");
	a_go_run: assert property (s_go |-> ##[1:2] !motion_stop)
		else $error("motion stop kept after start");
endmodule
bind tbw_ctrl tbw_ctrl_chk u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.phase_pulse, .timing_state_1, .check_mark, .format_clock, .unit_online, .unit_remote, .write_line,
	.write_amp_enable, .transfer_request, .checksum_load, .motion_stop, .tape_ready, .timing_track_wave);

/* File: verif/tbw_tape_model.sv */
/*
 tbw_tape_model: tape transport running forward, lines of five phase slots.
 assumes: bench picks the mark of the next line; data track reads all ones.
*/
`timescale 1ns/1ns
module tbw_tape_model #(
	parameter int FC_HALF = 188 // half period of the about 7.5 us format clock
) (
	input wire logic clk, // clock
	input wire logic rst_b, // reset, low
	input wire logic [3:0] mark_sel, // next mark: cm, fm, dm, bm
	output logic [4:0] phase_pulse, // phase pins
	output logic timing_state_1, // ts1 level
	output logic timing_state_4, // ts4 level
	output logic block_mark, // mark pin
	output logic data_mark, // mark pin
	output logic final_mark, // mark pin
	output logic check_mark, // mark pin
	output logic [2:0] read_data, // data track
	output logic format_clock, // format clock
	output logic line_end // last cycle of a line
);
	logic [5:0] slot;
	logic [3:0] mark;
	logic [8:0] fc_cnt;
	logic [2:0] pidx;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			slot <= 6'h00;
			mark <= 4'h0;
		end else begin
			slot <= line_end ? 6'h00 : slot + 6'h01;
			if (line_end)
				mark <= mark_sel;
		end
	end
	// the oscillator runs free, as a real one would
	always_ff @(posedge clk) begin
		if (!rst_b || fc_cnt == FC_HALF[8:0] - 9'h001) begin
			fc_cnt <= 9'h000;
			format_clock <= rst_b ? ~format_clock : 1'b0;
		end else
			fc_cnt <= fc_cnt + 9'h001;
	end
	// slot order gives pulses 4, 0, 1, 2, 3 within a line
	assign pidx = (slot[5:3] == 3'h0) ? 3'h4 : slot[5:3] - 3'h1;
	assign phase_pulse = (slot[2:0] >= 3'h2 && slot[2:0] <= 3'h4) ? (5'h01 << pidx) : 5'h00;
	assign timing_state_4 = slot[5:3] == 3'h0;
	assign timing_state_1 = slot[5:3] == 3'h2;
	assign {check_mark, final_mark, data_mark, block_mark} = mark;
	assign read_data = 3'h7;
	assign line_end = slot == 6'h27;
endmodule

/* File: verif/tbw_ctrl_tb.sv */
/*
 tbw_ctrl_tb: apb call sequences against tbw_ctrl with a tape model.
 assumes: package, checker and model compiled first; bench serves requests.
*/
`timescale 1ns/1ns
module tbw_ctrl_tb;
	import tbw_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic unit_online = 1'b0;
	logic unit_remote = 1'b0;
	logic unit_write_enabled = 1'b0;
	logic [3:0] mark_sel = 4'h0;
	logic [31:0] prdata, rd;
	logic [4:0] phase_pulse;
	logic [2:0] read_data, write_line;
	logic [11:0] tape_bus;
	logic pready, pslverr, timing_state_1, timing_state_4, block_mark, data_mark, final_mark, check_mark;
	logic format_clock, line_end, write_amp_enable, polarity, transfer_request, checksum_load, err, wv;
	logic motion_stop, tape_ready, timing_track_wave, mark_track_out;
	logic [7:0] adr [4] = '{OFF_MARKWIN, OFF_BLOCK, OFF_TAC, 8'h1C};
	logic [31:0] exp_v [4] = '{32'h0000000F, 32'h00007FFF, 32'h0, 32'h0};
	int fails = 0;
	int samples_checked = 0;
	int n;
	tbw_ctrl dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.phase_pulse, .timing_state_1, .timing_state_4, .block_mark, .data_mark, .final_mark, .check_mark,
		.forward(1'b1), .timing_window_closure(1'b0), .read_data, .format_clock, .unit_online, .unit_remote,
		.unit_write_enabled, .write_line, .write_amp_enable, .polarity, .transfer_request, .tape_bus,
		.checksum_load, .motion_stop, .tape_ready, .timing_track_wave, .mark_track_out);
	tbw_tape_model tape (.clk, .rst_b, .mark_sel, .phase_pulse, .timing_state_1, .timing_state_4, .block_mark,
		.data_mark, .final_mark, .check_mark, .read_data, .format_clock, .line_end);
	task automatic complete_run;
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one idle edge first, so psel is never driven twice in one time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			fails++;
			complete_run();
		end
	endtask
	task automatic wait_end;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (line_end !== 1'b1 && i < 100);
		if (i == 100) begin
			fails++;
			complete_run();
		end
	endtask
	// returns shortly after the marked line, leaving a blank line running
	task automatic line(input logic [3:0] m);
		mark_sel <= m;
		wait_end();
		mark_sel <= 4'h0;
		wait_end();
		repeat (8) @(posedge clk);
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("idle", rd[4:0], 5'h01);
		check("request", transfer_request, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h4);
		for (n = 0; n < 8; n++) begin
			{unit_online, unit_remote, unit_write_enabled} <= n[2:0];
			repeat (8) @(posedge clk);
			check("ready", tape_ready, {31'h0, &n[2:0]});
		end
		for (n = 0; n < 4; n++) begin
			apb(1'b1, adr[n], 32'hFFFFFFFF);
			apb(1'b0, adr[n], 32'h0);
			check("register", rd, exp_v[n]);
		end
		check("unmapped", err, 1'b1);
		apb(1'b1, OFF_BLOCK, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h104);
		line(4'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("search", rd[4:0], 5'h02);
		apb(1'b1, OFF_CTRL, 32'h200);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("preset", rd[4:0], 5'h01);
		apb(1'b1, OFF_CTRL, 32'h104);
		line(4'h0);
		line(4'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("block", rd[4:0], 5'h04);
		check("early request", transfer_request, 1'b0);
		line(4'h0);
		check("request", transfer_request, 1'b1);
		check("amps on", write_amp_enable, 1'b1);
		apb(1'b1, OFF_DATA, 32'hFFF);
		// the clear lands on the edge that completes the transfer
		@(posedge clk);
		check("served", transfer_request, 1'b0);
		line(4'h2);
		line(4'h4);
		check("polarity", polarity, 1'b1);
		line(4'h8);
		check("amps off", write_amp_enable, 1'b0);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("write end", rd[14:13], 2'h0);
		apb(1'b1, OFF_CTRL, 32'h107);
		line(4'h0);
		line(4'h1);
		line(4'h2);
		line(4'h4);
		line(4'h8);
		check("sum", tape_bus, GOOD_SUM);
		// the end decision waits for the next check mark in the check word state
		line(4'h8);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("check end", rd[14:13], 2'h0);
		apb(1'b1, OFF_CTRL, 32'h103);
		line(4'h0);
		line(4'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("move end", {rd[15:14], rd[4:0]}, 7'h41);
		apb(1'b1, OFF_MARKWIN, 32'hA);
		apb(1'b1, OFF_CTRL, 32'h20);
		n = 0;
		wv = timing_track_wave;
		for (int k = 0; k < 4000; k++) begin
			@(posedge clk);
			if (timing_track_wave !== wv)
				n++;
			wv = timing_track_wave;
		end
		check("wave", n > 9 && n < 12, 1'b1);
		check("mark out", mark_track_out, 1'b0);
		apb(1'b0, OFF_MARKWIN, 32'h0);
		check("mark window", rd, 32'h8);
		complete_run();
	end
endmodule
